// File: hw/sfa_consts.svh
// Shared constants for the serial flash address-mode decoder.
// Assumes inclusion by the package and both link ends.
`ifndef SFA_CONSTS_SVH
`define SFA_CONSTS_SVH
// Legacy instructions, address width follows the extended bit
`define SFA_OP_READ 8'h03
`define SFA_OP_FAST_READ 8'h0b
`define SFA_OP_DUAL_OUT 8'h3b
`define SFA_OP_QUAD_OUT 8'h6b
`define SFA_OP_DUAL_IO 8'hbb
`define SFA_OP_QUAD_IO 8'heb
`define SFA_OP_PAGE_PROG 8'h02
`define SFA_OP_QUAD_PROG 8'h32
`define SFA_OP_PARAM_ERASE 8'h20
`define SFA_OP_SECT_ERASE 8'hd8
// Instructions that always carry a 4-byte address
`define SFA_OP_W_READ 8'h13
`define SFA_OP_W_FAST 8'h0c
`define SFA_OP_W_DUAL_OUT 8'h3c
`define SFA_OP_W_QUAD_OUT 8'h6c
`define SFA_OP_W_DUAL_IO 8'hbc
`define SFA_OP_W_QUAD_IO 8'hec
`define SFA_OP_W_PAGE_PROG 8'h12
`define SFA_OP_W_QUAD_PROG 8'h34
`define SFA_OP_W_PARAM_ERASE 8'h21
`define SFA_OP_W_SECT_ERASE 8'hdc
`define SFA_OP_ECC_READ 8'h18
// Identification
`define SFA_OP_MFR_SIG 8'h90
`define SFA_OP_IDENT 8'h9f
`define SFA_OP_PARAMS 8'h5a
`define SFA_OP_ELEC_SIG 8'hab
// Register access
`define SFA_OP_SR1_RD 8'h05
`define SFA_OP_SR2_RD 8'h07
`define SFA_OP_CR1_RD 8'h35
`define SFA_OP_SR_CR_WR 8'h01
`define SFA_OP_WR_DIS 8'h04
`define SFA_OP_WR_EN 8'h06
`define SFA_OP_SR_CLEAR 8'h30
`define SFA_OP_BANK_RD 8'h16
`define SFA_OP_BANK_WR 8'h17
`define SFA_OP_BANK_ACC 8'hb9
`define SFA_OP_LEARN_RD 8'h41
`define SFA_OP_LEARN_NV 8'h43
`define SFA_OP_LEARN_WR 8'h4a
// Register fields and reset values
`define SFA_BANK_EXT_BIT 7
`define SFA_BANK_SEL_MASK 8'h03
`define SFA_BANK_DEF_MASK 8'h83
`define SFA_BANK_RESET 8'h00
`define SFA_SR1_WEL_BIT 1
`define SFA_SR1_EERR_BIT 5
`define SFA_SR1_PERR_BIT 6
`define SFA_SR1_WR_MASK 8'h9c
`define SFA_SR1_RESET 8'h00
`define SFA_SR2_RESET 8'h00
`define SFA_CR1_RESET 8'h00
`define SFA_LEARN_RESET 8'h00
// Timing: dummy clocks, host end-state gap count (select high at least 5 clk)
`define SFA_DUMMY_CLKS 4'd8
`define SFA_CS_GAP 3'd4
`endif

// File: hw/sfa_pkg.sv
// Types and opcode classes shared by both link ends.
// Assumes the constants header is on the include path.
`include "sfa_consts.svh"
package sfa_pkg;
    typedef enum logic [3:0] {
        PH_OP = 4'h1,
        PH_ADDR = 4'h2,
        PH_DUMMY = 4'h4,
        PH_DATA = 4'h8
    } sfa_phase_t;

    typedef enum logic [6:0] {
        H_IDLE = 7'h01,
        H_OP = 7'h02,
        H_ADDR = 7'h04,
        H_DUMMY = 7'h08,
        H_WR = 7'h10,
        H_RD = 7'h20,
        H_END = 7'h40
    } sfa_host_st_t;

    function automatic logic op_is_legacy_addr(input logic [7:0] op);
        return op == `SFA_OP_READ || op == `SFA_OP_FAST_READ ||
            op == `SFA_OP_DUAL_OUT || op == `SFA_OP_QUAD_OUT ||
            op == `SFA_OP_DUAL_IO || op == `SFA_OP_QUAD_IO ||
            op == `SFA_OP_PAGE_PROG || op == `SFA_OP_QUAD_PROG ||
            op == `SFA_OP_PARAM_ERASE || op == `SFA_OP_SECT_ERASE;
    endfunction

    function automatic logic op_is_wide_addr(input logic [7:0] op);
        return op == `SFA_OP_W_READ || op == `SFA_OP_W_FAST ||
            op == `SFA_OP_W_DUAL_OUT || op == `SFA_OP_W_QUAD_OUT ||
            op == `SFA_OP_W_DUAL_IO || op == `SFA_OP_W_QUAD_IO ||
            op == `SFA_OP_W_PAGE_PROG || op == `SFA_OP_W_QUAD_PROG ||
            op == `SFA_OP_W_PARAM_ERASE || op == `SFA_OP_W_SECT_ERASE ||
            op == `SFA_OP_ECC_READ;
    endfunction

    function automatic logic op_has_dummy(input logic [7:0] op);
        return op == `SFA_OP_FAST_READ || op == `SFA_OP_DUAL_OUT ||
            op == `SFA_OP_QUAD_OUT || op == `SFA_OP_DUAL_IO ||
            op == `SFA_OP_QUAD_IO || op == `SFA_OP_W_FAST ||
            op == `SFA_OP_W_DUAL_OUT || op == `SFA_OP_W_QUAD_OUT ||
            op == `SFA_OP_W_DUAL_IO || op == `SFA_OP_W_QUAD_IO;
    endfunction

    function automatic logic op_is_array_read(input logic [7:0] op);
        return op == `SFA_OP_READ || op == `SFA_OP_W_READ ||
            op_has_dummy(op);
    endfunction
endpackage

// File: hw/sfa_link_if.sv
// Serial link between host controller and flash decoder.
// Assumes the bench instantiates it and joins both ends.
`timescale 1ns/10ps
interface sfa_link_if;
    logic sck;
    logic cs_n;
    logic si;
    logic so;
    logic so_oe_n;
    logic so_line;

    // Output line idles high while the device does not drive it
    assign so_line = so_oe_n ? 1'b1 : so;

    modport dev (input sck, input cs_n, input si, output so,
        output so_oe_n);
    modport host (output sck, output cs_n, output si, input so_line);
endinterface

// File: hw/sfa_device.sv
// Flash-side instruction decoder, address former and bank register.
// Assumes link mode 0 and an array model answering rd_addr at once.
//
// Notes on behaviour
// - Reset clears extended bit; 24-bit addressing.
// - Extended bit set: legacy commands take 32 bits.
// - Legacy reads decode as width-switchable.
// - Legacy program/erase follow the extended bit.
// - Short address is offset in selected bank.
// - Host sets bank before reaching higher memory.
// - Bank bits form the fourth address byte.
// - Bank bits volatile; bank zero after power-up.
// - Reads stream across banks without delay.
// - Bank applies at start; never auto-updated.
// - Bank bits zero map to address zero.
// - Decode identification reads; host slows signature.
// - Return status one, two, config one.
// - Decode register write, write disable, enable.
// - Status clear resets failure flags.
// - ECC status read always takes 4 bytes.
// - Bank register read and byte write.
// - Old power-down code accesses the bank register.
// - Decode learning pattern read, program, write.
// - Wide-address instructions always take 32 bits.
// - Address arrives most significant byte first.
// - Commands open with serial 8-bit instruction.
`timescale 1ns/10ps
`include "sfa_consts.svh"
module sfa_device
    import sfa_pkg::*;
#(
    parameter logic [7:0] ID_BYTE = 8'ha5 // Arbitrary value
)
(
    // Link and reset
    sfa_link_if.dev link,
    input wire logic reset_n,
    // Command and address report, link clock domain
    output logic cmd_valid,
    output logic [7:0] cmd_opcode,
    output logic addr_valid,
    output logic [31:0] start_addr,
    // Array read port
    output logic [31:0] rd_addr,
    input wire logic [7:0] rd_data,
    // Program data and learning program
    output logic wr_valid,
    output logic nv_learn_prog,
    output logic [7:0] wr_data,
    // Array failure events and register view
    input wire logic prog_fail,
    input wire logic erase_fail,
    output logic [7:0] bank_reg,
    output logic [7:0] status_one
);
    sfa_phase_t ph_q, ph_d;
    logic [2:0] bit_q;
    logic [7:0] sh_q;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] op_q;
    logic four_q;
    logic dbyte_q;
    logic [23:0] addr_q;
    logic [7:0] bank_q, bank_d;
    logic [7:0] sr1_q, sr1_d;
    logic [7:0] cr1_q, cr1_d;
    logic [7:0] learn_q, learn_d;
    logic [31:0] rd_addr_q, rd_addr_d;
    logic [7:0] tx_q;
    logic drv_q;
    logic frame_rst_n;
    logic [7:0] rx_byte;
    logic byte_end, op_end, addr_end, data_end;
    logic new_legacy, new_wide, new_four;
    logic [31:0] full_addr, start_d;
    logic array_rd, op_reads, first_byte;
    logic wr_bank, wr_sr, wr_cr, wr_learn, prog_op;
    logic [7:0] tx_src;
    //////////////////////////////////////////////////////////////////////
    // Frame decode
    // Chip select high clears the frame; the link clock stops then
    assign frame_rst_n = reset_n & ~link.cs_n;
    assign rx_byte = {sh_q[6:0], link.si};
    assign byte_end = (bit_q == 3'd7) & (ph_q != PH_DUMMY);
    assign op_end = byte_end & (ph_q == PH_OP);
    assign addr_end = byte_end & (ph_q == PH_ADDR) & (cnt_q == 4'd0);
    assign data_end = byte_end & (ph_q == PH_DATA);
    assign first_byte = data_end & ~dbyte_q;
    assign new_legacy = op_is_legacy_addr(rx_byte);
    assign new_wide = op_is_wide_addr(rx_byte);
    // Extended bit sampled at instruction end only
    assign new_four = new_wide |
        (new_legacy & bank_q[`SFA_BANK_EXT_BIT]);
    // Address assembly, MSB first, bank as top byte
    assign full_addr = {addr_q, rx_byte};
    assign start_d = four_q ? full_addr :
        {bank_q & `SFA_BANK_SEL_MASK, full_addr[23:0]};
    //////////////////////////////////////////////////////////////////////
    // Phase sequencing
    always_comb begin
        ph_d = ph_q;
        cnt_d = cnt_q;
        case (ph_q)
            PH_OP: begin
                if (op_end) begin
                    ph_d = (new_legacy | new_wide) ? PH_ADDR : PH_DATA;
                    cnt_d = new_four ? 4'd3 : 4'd2;
                end
            end
            PH_ADDR: begin
                if (byte_end) begin
                    cnt_d = cnt_q - 4'd1;
                    if (cnt_q == 4'd0) begin
                        ph_d = op_has_dummy(op_q) ? PH_DUMMY : PH_DATA;
                        cnt_d = `SFA_DUMMY_CLKS - 4'd1;
                    end
                end
            end
            PH_DUMMY: begin
                cnt_d = cnt_q - 4'd1;
                if (cnt_q == 4'd0) begin
                    ph_d = PH_DATA;
                end
            end
            PH_DATA: ph_d = PH_DATA;
            default: ph_d = PH_OP;
        endcase
    end
    // Frame state; the bit counter rests during dummy clocks
    always_ff @(posedge link.sck or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            ph_q <= PH_OP;
            bit_q <= 3'd0;
            sh_q <= 8'h00;
            cnt_q <= 4'd0;
            op_q <= 8'h00;
            four_q <= 1'b0;
            dbyte_q <= 1'b0;
            addr_q <= 24'h000000;
        end else begin
            ph_q <= ph_d;
            bit_q <= (ph_q == PH_DUMMY) ? 3'd0 : bit_q + 3'd1;
            sh_q <= rx_byte;
            cnt_q <= cnt_d;
            if (op_end) begin
                op_q <= rx_byte;
                four_q <= new_four;
            end
            if (byte_end & (ph_q == PH_ADDR)) begin
                addr_q <= full_addr[23:0];
            end
            if (data_end) begin
                dbyte_q <= 1'b1;
            end
        end
    end
    //////////////////////////////////////////////////////////////////////
    // Register writes
    assign wr_bank = first_byte & ((op_q == `SFA_OP_BANK_WR) |
        (op_q == `SFA_OP_BANK_ACC));
    assign bank_d = wr_bank ? (rx_byte & `SFA_BANK_DEF_MASK) :
        bank_q;
    assign wr_sr = first_byte & (op_q == `SFA_OP_SR_CR_WR);
    assign wr_cr = data_end & dbyte_q & (op_q == `SFA_OP_SR_CR_WR);
    assign cr1_d = wr_cr ? rx_byte : cr1_q;
    assign wr_learn = first_byte & (op_q == `SFA_OP_LEARN_WR);
    assign learn_d = wr_learn ? rx_byte : learn_q;
    assign prog_op = op_is_legacy_addr(op_q) | op_is_wide_addr(op_q);
    // Status one; a failure event beats a clear in the same cycle
    always_comb begin
        sr1_d = sr1_q;
        if (wr_sr) begin
            sr1_d = (sr1_q & ~`SFA_SR1_WR_MASK) |
                (rx_byte & `SFA_SR1_WR_MASK);
        end
        if (op_end & (rx_byte == `SFA_OP_WR_EN)) begin
            sr1_d[`SFA_SR1_WEL_BIT] = 1'b1;
        end
        if (op_end & (rx_byte == `SFA_OP_WR_DIS)) begin
            sr1_d[`SFA_SR1_WEL_BIT] = 1'b0;
        end
        if (op_end & (rx_byte == `SFA_OP_SR_CLEAR)) begin
            sr1_d[`SFA_SR1_EERR_BIT] = 1'b0;
            sr1_d[`SFA_SR1_PERR_BIT] = 1'b0;
        end
        if (prog_fail) begin
            sr1_d[`SFA_SR1_PERR_BIT] = 1'b1;
        end
        if (erase_fail) begin
            sr1_d[`SFA_SR1_EERR_BIT] = 1'b1;
        end
    end
    // Read pointer: loaded once, then walks freely past bank edges
    assign array_rd = op_is_array_read(op_q);
    assign rd_addr_d = addr_end ? start_d :
        (data_end & array_rd) ? rd_addr_q + 32'h1 :
        rd_addr_q;
    // Volatile state, cleared only by reset
    always_ff @(posedge link.sck or negedge reset_n) begin
        if (!reset_n) begin
            bank_q <= `SFA_BANK_RESET;
            sr1_q <= `SFA_SR1_RESET;
            cr1_q <= `SFA_CR1_RESET;
            learn_q <= `SFA_LEARN_RESET;
            cmd_opcode <= 8'h00;
            start_addr <= 32'h00000000;
            rd_addr_q <= 32'h00000000;
            wr_data <= 8'h00;
        end else begin
            bank_q <= bank_d;
            sr1_q <= sr1_d;
            cr1_q <= cr1_d;
            learn_q <= learn_d;
            rd_addr_q <= rd_addr_d;
            if (op_end) begin
                cmd_opcode <= rx_byte;
            end
            if (addr_end) begin
                start_addr <= start_d;
            end
            if (data_end) begin
                wr_data <= rx_byte;
            end
        end
    end
    // Event pulses, cut short if the frame ends
    always_ff @(posedge link.sck or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            cmd_valid <= 1'b0;
            addr_valid <= 1'b0;
            wr_valid <= 1'b0;
            nv_learn_prog <= 1'b0;
        end else begin
            cmd_valid <= op_end;
            addr_valid <= addr_end;
            wr_valid <= data_end & prog_op;
            nv_learn_prog <= first_byte & (op_q == `SFA_OP_LEARN_NV);
        end
    end
    //////////////////////////////////////////////////////////////////////
    // Read data source per instruction
    assign tx_src = (array_rd | (op_q == `SFA_OP_ECC_READ)) ? rd_data :
        (op_q == `SFA_OP_SR1_RD) ? sr1_q :
        (op_q == `SFA_OP_SR2_RD) ? `SFA_SR2_RESET :
        (op_q == `SFA_OP_CR1_RD) ? cr1_q :
        (op_q == `SFA_OP_BANK_RD) ? bank_q :
        (op_q == `SFA_OP_LEARN_RD) ? learn_q : ID_BYTE;
    assign op_reads = array_rd | (op_q == `SFA_OP_ECC_READ) |
        (op_q == `SFA_OP_SR1_RD) | (op_q == `SFA_OP_SR2_RD) |
        (op_q == `SFA_OP_CR1_RD) | (op_q == `SFA_OP_BANK_RD) |
        (op_q == `SFA_OP_LEARN_RD) | (op_q == `SFA_OP_MFR_SIG) |
        (op_q == `SFA_OP_IDENT) | (op_q == `SFA_OP_PARAMS) |
        (op_q == `SFA_OP_ELEC_SIG);
    // Shift out on the falling edge so the host samples on rising
    always_ff @(negedge link.sck or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            tx_q <= 8'h00;
            drv_q <= 1'b0;
        end else if ((ph_q == PH_DATA) & (bit_q == 3'd0) & op_reads) begin
            tx_q <= tx_src;
            drv_q <= 1'b1;
        end else begin
            tx_q <= {tx_q[6:0], 1'b0};
        end
    end
    assign link.so = tx_q[7];
    assign link.so_oe_n = ~drv_q;
    assign rd_addr = rd_addr_q;
    assign bank_reg = bank_q;
    assign status_one = sr1_q;
endmodule

// File: hw/sfa_host.sv
// Host-side serial controller: sends one command per request.
// Assumes clk at 10 MHz; link clock is clk divided by four.
`timescale 1ns/10ps
`include "sfa_consts.svh"
module sfa_host
    import sfa_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Link
    sfa_link_if.host link,
    // Command request
    input wire logic start,
    input wire logic [7:0] opcode,
    input wire logic [31:0] addr,
    input wire logic [7:0] wr_count,
    input wire logic [7:0] rd_count,
    output logic ready,
    // Data and completion
    input wire logic [7:0] wr_data,
    output logic wr_take,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic done,
    output logic ext_mode
);

    sfa_host_st_t st_q, st_d, nxt_st;
    logic [1:0] ph_q;
    logic [2:0] bit_q;
    logic [7:0] sh_q, op_q;
    logic [31:0] asr_q;
    logic [2:0] na_q, n_addr;
    logic [3:0] nd_q;
    logic [7:0] nw_q, nr_q;
    logic [2:0] gap_q;
    logic cs_n_q, so_s1_q, so_s2_q, ext_q;
    logic active, tick, unit_done, take_d;
    logic more_a, more_d, more_w, more_r;
    logic [7:0] rx_byte, next_byte;

    //////////////////////////////////////////////////////////////////////
    // Sequencing terms
    // 2.5 MHz link clock, well under the signature-read limit
    assign active = (st_q != H_IDLE) & (st_q != H_END);
    assign tick = active & (ph_q == 2'd3);
    assign unit_done = tick & ((st_q == H_DUMMY) | (bit_q == 3'd7));
    assign more_a = na_q > {2'b00, st_q == H_ADDR};
    assign more_d = nd_q > {3'b000, st_q == H_DUMMY};
    assign more_w = nw_q > {7'h00, st_q == H_WR};
    assign more_r = nr_q > {7'h00, st_q == H_RD};
    assign nxt_st = more_a ? H_ADDR : more_d ? H_DUMMY :
        more_w ? H_WR : more_r ? H_RD : H_END;
    assign rx_byte = {sh_q[6:0], so_s2_q};
    assign next_byte = (nxt_st == H_ADDR) ? asr_q[31:24] :
        (nxt_st == H_WR) ? wr_data : 8'h00;
    assign take_d = unit_done & (nxt_st == H_WR);
    // Address length from opcode class and the shadowed extended bit
    assign n_addr = op_is_wide_addr(opcode) ? 3'd4 :
        op_is_legacy_addr(opcode) ? (ext_q ? 3'd4 : 3'd3) :
        3'd0;
    assign ready = (st_q == H_IDLE);

    always_comb begin
        st_d = st_q;
        case (st_q)
            H_IDLE: if (start) st_d = H_OP;
            H_OP, H_ADDR, H_DUMMY, H_WR, H_RD: begin
                if (unit_done) st_d = nxt_st;
            end
            H_END: if (gap_q == `SFA_CS_GAP) st_d = H_IDLE;
            default: st_d = H_IDLE;
        endcase
    end

    //////////////////////////////////////////////////////////////////////
    // Control and link pins; select rises one clk after the last fall
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= H_IDLE;
            ph_q <= 2'd0;
            cs_n_q <= 1'b1;
            gap_q <= 3'd0;
            so_s1_q <= 1'b1;
            so_s2_q <= 1'b1;
        end else begin
            st_q <= st_d;
            ph_q <= active ? ph_q + 2'd1 : 2'd0;
            cs_n_q <= (st_d == H_IDLE) | (st_q == H_END);
            gap_q <= (st_q == H_END) ? gap_q + 3'd1 : 3'd0;
            so_s1_q <= link.so_line;
            so_s2_q <= so_s1_q;
        end
    end

    // Shift path: instruction first, then address, dummy, data
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sh_q <= 8'h00;
            op_q <= 8'h00;
            bit_q <= 3'd0;
            asr_q <= 32'h00000000;
            na_q <= 3'd0;
            nd_q <= 4'd0;
            nw_q <= 8'h00;
            nr_q <= 8'h00;
        end else if ((st_q == H_IDLE) & start) begin
            sh_q <= opcode;
            op_q <= opcode;
            bit_q <= 3'd0;
            asr_q <= (n_addr == 3'd3) ? {addr[23:0], 8'h00} : addr;
            na_q <= n_addr;
            nd_q <= op_has_dummy(opcode) ? `SFA_DUMMY_CLKS : 4'd0;
            nw_q <= wr_count;
            nr_q <= rd_count;
        end else if (unit_done) begin
            sh_q <= next_byte;
            bit_q <= 3'd0;
            na_q <= na_q - {2'b00, st_q == H_ADDR};
            nd_q <= nd_q - {3'b000, st_q == H_DUMMY};
            nw_q <= nw_q - {7'h00, st_q == H_WR};
            nr_q <= nr_q - {7'h00, st_q == H_RD};
            if (nxt_st == H_ADDR) begin
                asr_q <= {asr_q[23:0], 8'h00};
            end
        end else if (tick) begin
            sh_q <= rx_byte;
            bit_q <= bit_q + 3'd1;
        end
    end

    // User-side pulses and the extended-bit shadow
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_take <= 1'b0;
            rd_valid <= 1'b0;
            rd_data <= 8'h00;
            done <= 1'b0;
            ext_q <= 1'b0;
        end else begin
            wr_take <= take_d;
            rd_valid <= unit_done & (st_q == H_RD);
            done <= (st_q == H_END) & (st_d == H_IDLE);
            if (unit_done & (st_q == H_RD)) begin
                rd_data <= rx_byte;
            end
            if (take_d & ((op_q == `SFA_OP_BANK_WR) |
                    (op_q == `SFA_OP_BANK_ACC))) begin
                ext_q <= wr_data[`SFA_BANK_EXT_BIT];
            end
        end
    end

    assign link.sck = ph_q[1];
    assign link.cs_n = cs_n_q;
    assign link.si = sh_q[7];
    assign ext_mode = ext_q;
endmodule

// File: test/sfa_link_checker.sv
// Wire-level checks on the serial link between host and decoder.
// Assumes clk is the host clock that paces every link edge.
`timescale 1ns/10ps
module sfa_link_checker (
    // Host clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Link signals
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic so,
    input wire logic so_oe_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////
    // Rising link edges in a frame, modulo eight, so byte framing shows
    logic sck_q;
    logic [2:0] bits_q;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sck_q <= 1'b0;
            bits_q <= 3'd0;
        end else begin
            sck_q <= sck;
            bits_q <= cs_n ? 3'd0 : bits_q + 3'(sck & !sck_q);
        end
    end
    ////////////////////////////////////////////////////////////
    // Link clock rests low around frame edges
    sequence s_sck_low2;
        !sck ##1 !sck;
    endsequence
    a_frame_opens_low: assert property ($fell(cs_n) |-> s_sck_low2)
        else $error("link clock not low as frame opens");
    a_frame_ends_low: assert property ($rose(cs_n) |-> s_sck_low2)
        else $error("link clock not low as frame ends");
    a_byte_frames: assert property ($rose(cs_n) |-> bits_q == 3'd0)
        else $error("frame not a whole number of bytes");
    a_gap_five: assert property ($rose(cs_n) |-> cs_n [*5])
        else $error("deselect gap shorter than five clocks");
    a_sck_high_two: assert property ($rose(sck) |=> sck ##1 !sck)
        else $error("link clock high phase not two clocks");
    // Data lines may only move on the falling link edge
    a_si_holds_high: assert property ($rose(sck) |=> $stable(si))
        else $error("host data moved while clock high");
    a_so_holds_high: assert property ($rose(sck) |=> $stable(so))
        else $error("device data moved while clock high");
    a_oe_on_fall: assert property ($fell(so_oe_n) |-> $fell(sck))
        else $error("device drive began off the falling edge");
    a_oe_release: assert property (cs_n && $past(cs_n) |-> so_oe_n)
        else $error("device drives while deselected");
endmodule

// File: test/tb.sv
// Self-checking bench: host controller and decoder joined by the link.
// Assumes the host derives the link clock from clk by itself.
`timescale 1ns/10ps
module tb;
    localparam logic [7:0] ID = 8'h3c; // Arbitrary value
    logic clk = 1'b0, reset_n = 1'b0, start = 1'b0, pf = 1'b0, ef = 1'b0;
    logic [7:0] op = 8'h00, wc = 8'h00, rc = 8'h00, wd = 8'h00, bk = 8'h00;
    logic [31:0] ad = 32'h0, a, e;
    logic rd, ready, wr_take, rd_valid, done, ext_mode, nvp, cv, av, wv;
    logic [7:0] rdd, hrd, cop, wdo, bank_reg, sr1;
    logic [31:0] sa, ra;
    logic [7:0] rq[$];
    logic [7:0] ops[21] = '{8'h03, 8'h0b, 8'h3b, 8'h6b, 8'hbb, 8'heb, 8'h02,
        8'h32, 8'h20, 8'hd8, 8'h13, 8'h0c, 8'h3c, 8'h6c, 8'hbc, 8'hec, 8'h12,
        8'h34, 8'h21, 8'hdc, 8'h18};
    logic [7:0] ids[4] = '{8'h90, 8'h9f, 8'h5a, 8'hab};
    int errors = 0, num_checks = 0, cyc = 0, nlp = 0, seed = 32'hd91f;
    ////////////////////////////////////////////////////////////
    // Both ends and the wire checker
    sfa_link_if lk();
    sfa_host sfa_host_inst (.clk(clk), .reset_n(reset_n), .link(lk.host),
        .start(start), .opcode(op), .addr(ad), .wr_count(wc), .rd_count(rc),
        .ready(ready), .wr_data(wd), .wr_take(wr_take), .rd_data(hrd),
        .rd_valid(rd_valid), .done(done), .ext_mode(ext_mode));
    sfa_device #(.ID_BYTE(ID)) sfa_device_inst (.link(lk.dev),
        .reset_n(reset_n), .cmd_valid(cv), .cmd_opcode(cop), .addr_valid(av),
        .start_addr(sa), .rd_addr(ra), .rd_data(rdd), .wr_valid(wv),
        .nv_learn_prog(nvp), .wr_data(wdo), .prog_fail(pf), .erase_fail(ef),
        .bank_reg(bank_reg), .status_one(sr1));
    sfa_link_checker sfa_link_checker_inst (.clk(clk), .reset_n(reset_n),
        .sck(lk.sck), .cs_n(lk.cs_n), .si(lk.si), .so(lk.so),
        .so_oe_n(lk.so_oe_n));
    ////////////////////////////////////////////////////////////
    // Array model: byte depends on address bytes 0, 1 and 3, so a bank slip shows
    function automatic logic [7:0] arr(input logic [31:0] x);
        return x[7:0] ^ x[15:8] ^ x[31:24];
    endfunction
    assign rdd = arr(ra);
    // Clock, read byte capture, learning pulses and hang guard
    initial forever #50 clk = ~clk;
    always @(posedge nvp) nlp++;
    always @(posedge clk) begin
        cyc++;
        if (rd_valid === 1'b1) rq.push_back(hrd);
        if (cyc == 60000) begin
            errors++;
            close_out();
        end
    end
    ////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] x, g);
        num_checks++;
        if (g !== x) begin
            errors++;
            $display("BAD %s exp %h got %h", nm, x, g);
        end
    endtask
    // One host command; waits for done under a bound
    task automatic cmd(input logic [7:0] o, input logic [31:0] ai,
        input logic [7:0] w, r, d);
        int n = 0;
        rq.delete();
        @(posedge clk);
        #5;
        op = o;
        ad = ai;
        wc = w;
        rc = r;
        wd = d;
        start = 1'b1;
        @(posedge clk);
        #5;
        start = 1'b0;
        chk("busy", 0, ready);
        while (done !== 1'b1 && n < 4000) begin
            @(posedge clk);
            #5;
            n++;
        end
        chk("done", 1, n < 4000);
        @(posedge clk);
    endtask
    // Bank write, then view, readback and host shadow
    task automatic setb(input logic [7:0] o, v);
        cmd(o, 0, 1, 0, v);
        bk = v & 8'h83;
        chk("bank", bk, bank_reg);
        cmd(8'h16, 0, 0, 1, 0);
        chk("bank_rd", bk, rq[0]);
        chk("ext", bk[7], ext_mode);
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk);
        #5;
        reset_n = 1'b1;
        chk("bank_rst", 8'h00, bank_reg);
        cmd(8'h16, 0, 0, 1, 0);
        chk("bank_rd0", 8'h00, rq[0]);
        // Every addressed opcode at bank 0, bank 2, then 32-bit mode
        for (int p = 0; p < 3; p++) begin
            if (p == 1) setb(8'h17, {1'b0, 5'($random(seed)), 2'b10});
            if (p == 2) setb(8'hb9, 8'hff);
            foreach (ops[i]) begin
                a = $random(seed);
                rd = i < 6 || (i > 9 && i < 16) || i == 20;
                cmd(ops[i], a, 8'(i % 10 == 6 || i % 10 == 7),
                    rd ? 8'd2 : 8'd0, a[7:0]);
                e = (i > 9 || bk[7]) ? a : {6'h0, bk[1:0], a[23:0]};
                chk("opcode", ops[i], cop);
                chk("start", e, sa);
                if (wc) chk("wdata", a[7:0], wdo);
                if (rd) chk("rd0", arr(e), rq[0]);
                if (rd && i != 20) chk("rd1", arr(e + 1), rq[1]);
            end
        end
        // Streaming across a bank boundary leaves the register alone
        cmd(8'h03, 32'h00ffffff, 0, 2, 0);
        chk("cross", arr(32'h01000000), rq[1]);
        chk("bank_keep", 8'h83, bank_reg);
        setb(8'h17, 8'h00);
        #5;
        pf = 1'b1;
        ef = 1'b1;
        cmd(8'h07, 0, 0, 1, 0);
        chk("sr2", 8'h00, rq[0]);
        #5;
        pf = 1'b0;
        ef = 1'b0;
        cmd(8'h05, 0, 0, 1, 0);
        chk("sr1_rd", 8'h60, rq[0]);
        cmd(8'h30, 0, 0, 0, 0);
        chk("clear", 8'h00, sr1);
        cmd(8'h06, 0, 0, 0, 0);
        chk("wel", 8'h02, sr1);
        cmd(8'h35, 0, 0, 1, 0);
        chk("cr1", 8'h00, rq[0]);
        cmd(8'h01, 0, 2, 0, 8'hff);
        chk("wrr", 8'h9c, sr1 & 8'h9c);
        cmd(8'h04, 0, 0, 0, 0);
        chk("wel_off", 1'b0, sr1[1]);
        foreach (ids[i]) begin
            cmd(ids[i], 0, 0, 1, 0);
            chk("id", ID, rq[0]);
        end
        cmd(8'h4a, 0, 1, 0, 8'h55);
        cmd(8'h41, 0, 0, 1, 0);
        chk("learn", 8'h55, rq[0]);
        cmd(8'h43, 0, 1, 0, 8'h96);
        chk("nv_prog", 1, nlp);
        close_out();
    end
endmodule
